/* File: pkg/power_pkg.sv */
// ****************************************************************
// Shared constants and types for the sleep, wake and reset sequencer
// ****************************************************************
package power_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CLK_HZ        = 10_000_000;
   localparam int CLK_PERIOD_NS = 100;
   localparam int RTC_HZ        = 32_768;         // Always-on 32 kHz time base
   localparam int WAKE_DELAY_NS = 50_000;         // Clock settle time after wake
   localparam int RST_PULSE_NS  = 20_000;         // Reset pin pull-down pulse

   // Divider length for the RTC enable, rounded down
   localparam logic [8:0] RTC_DIV_CYC    = 9'(CLK_HZ / RTC_HZ);
   // Least times, rounded up to whole cycles
   localparam logic [8:0] WAKE_DELAY_CYC =
      9'((WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] RST_PULSE_CYC  =
      8'((RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ****************************************************************
   // Widths and reset values
   // ****************************************************************
   localparam int GPIO_W = 10;
   localparam int SEL_W  = 4;
   localparam int RTC_W  = 16;
   localparam int WDOG_W = 16;

   // Watchdog timeout in RTC ticks (one second)
   localparam logic [WDOG_W-1:0] WDOG_TICKS_DEF = 16'h8000;
   localparam logic [RTC_W-1:0]  RTC_CNT_RST    = 16'h0000;
   localparam logic              PIN_RELEASED   = 1'b1;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_RESET,
      ST_WAKING,
      ST_ACTIVE,
      ST_LIGHT,
      ST_DEEP
   } pwr_state_e;

   // Power and clock controls handed to the rest of the module
   typedef struct packed {
      logic core_run;
      logic sys_clk_on;
      logic periph_on;
      logic uart_on;
      logic radio_on;
      logic ram_retain;
      logic rtc_run;
   } pwr_ctrl_s;

   // Wake sources
   typedef struct packed {
      logic wake_pin;
      logic gpio;
      logic radio;
      logic rtc;
   } wake_src_s;

   localparam pwr_ctrl_s PWR_RESET = 7'h23;  // Clock on, radio off, retain, rtc
   localparam wake_src_s WAKE_NONE = 4'h0;

endpackage

/* File: core/sync_2ff.sv */
`timescale 1ns/10ps
// ****************************************************************
// Two-stage synchroniser for asynchronous pin levels
// ****************************************************************
module sync_2ff #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         sys_clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] data_i,
   output logic      [W-1:0] data_o
);

   logic [W-1:0] meta_q;
   logic [W-1:0] data_q;

   // First stage feeds only the second stage
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         meta_q <= RST_VAL;
         data_q <= RST_VAL;
      end else begin
         meta_q <= data_i;
         data_q <= meta_q;
      end
   end

   assign data_o = data_q;

endmodule

/* File: core/power_state_ctrl.sv */
`timescale 1ns/10ps
module power_state_ctrl #(
   parameter logic [power_pkg::WDOG_W-1:0] WDOG_TICKS = power_pkg::WDOG_TICKS_DEF
) (
   input  wire logic                           sys_clk_i,
   input  wire logic                           reset_i,
   input  wire logic                           reset_pin_i,
   output logic                                reset_pin_o,
   output logic                                reset_pin_oe_o,
   input  wire logic [power_pkg::GPIO_W-1:0]   gpio_i,
   input  wire logic [power_pkg::GPIO_W-1:0]   gpio_irq_en_i,
   input  wire logic                           wake_pin_en_i,
   input  wire logic [power_pkg::SEL_W-1:0]    wake_pin_sel_i,
   input  wire logic                           sleep_en_i,
   input  wire logic                           core_idle_i,
   input  wire logic                           irq_done_i,
   input  wire logic                           radio_activity_i,
   input  wire logic                           rtc_alarm_en_i,
   input  wire logic [power_pkg::RTC_W-1:0]    rtc_alarm_i,
   input  wire logic                           wdog_kick_i,
   output power_pkg::pwr_ctrl_s                pwr_ctrl_o,
   output power_pkg::pwr_state_e               pwr_state_o,
   output power_pkg::wake_src_s                wake_cause_o,
   output logic                                sys_reset_o,
   output logic                                uart_flow_ready_o,
   output logic                                gpio_busy_o,
   output logic      [power_pkg::RTC_W-1:0]    rtc_count_o
);
   import power_pkg::*;

   // ****************************************************************
   // Functions
   // ****************************************************************

   // One-hot mask for the GPIO that carries the wake function
   function automatic logic [GPIO_W-1:0] pin_mask(input logic [SEL_W-1:0] sel);
      logic [GPIO_W-1:0] m;
      m = '0;
      for (int i = 0; i < GPIO_W; i++) begin
         if (SEL_W'(i) == sel) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   // Power controls for each state
   function automatic pwr_ctrl_s ctrl_for(input pwr_state_e st);
      pwr_ctrl_s c;
      c            = PWR_RESET;
      c.ram_retain = 1'b1;
      c.rtc_run    = 1'b1;
      case (st)
         ST_ACTIVE: begin
            c.core_run   = 1'b1;
            c.sys_clk_on = 1'b1;
            c.periph_on  = 1'b1;
            c.uart_on    = 1'b1;
            c.radio_on   = 1'b1;
         end
         ST_LIGHT: begin
            c.core_run   = 1'b0;
            c.sys_clk_on = 1'b1;
            c.periph_on  = 1'b1;
            c.uart_on    = 1'b1;
            c.radio_on   = 1'b1;
         end
         ST_WAKING: begin
            c.core_run   = 1'b0;
            c.sys_clk_on = 1'b1;                 // Clocks restart and settle
            c.periph_on  = 1'b0;
            c.uart_on    = 1'b0;
            c.radio_on   = 1'b1;
         end
         ST_DEEP: begin
            c.core_run   = 1'b0;
            c.sys_clk_on = 1'b0;
            c.periph_on  = 1'b0;
            c.uart_on    = 1'b0;
            c.radio_on   = 1'b1;
         end
         default: begin
            c.core_run   = 1'b0;
         end
      endcase
      return c;
   endfunction

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [GPIO_W:0]   sync_in;
   logic [GPIO_W:0]   sync_out;
   logic [GPIO_W-1:0] gpio_s;
   logic              pin_s;
   logic [GPIO_W-1:0] gpio_prev_q;
   logic [GPIO_W-1:0] gpio_rise;
   logic [GPIO_W-1:0] wake_mask;
   logic              wake_lvl;
   logic              gpio_evt;
   logic              rtc_evt;
   wake_src_s         src;
   logic              any_wake;
   logic              busy_q;
   logic              busy_d;
   logic              deep_ok;

   logic [8:0]        div_cnt_q;
   logic              tick_q;
   logic [RTC_W-1:0]  rtc_cnt_q;
   logic [WDOG_W-1:0] wdog_cnt_q;
   logic              wdog_run;
   logic              wdog_expire;
   logic [7:0]        rst_cnt_q;
   logic [7:0]        rst_cnt_d;
   logic              rst_any;

   pwr_state_e        state_q;
   pwr_state_e        state_d;
   logic [8:0]        wake_cnt_q;
   logic              enter_wake;
   wake_src_s         cause_q;
   pwr_ctrl_s         pwr_q;
   logic              flow_q;
   logic              sys_rst_q;
   logic              pin_oe_q;
   logic              pin_val_q;

   // ****************************************************************
   // Input synchronisation
   // ****************************************************************

   // Pin levels enter through two flops before any logic sees them
   assign sync_in = {reset_pin_i, gpio_i};

   sync_2ff #(
      .W       (GPIO_W + 1),
      .RST_VAL ({PIN_RELEASED, {GPIO_W{1'b0}}})
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .data_i    (sync_in),
      .data_o    (sync_out)
   );

   assign gpio_s = sync_out[GPIO_W-1:0];
   assign pin_s  = sync_out[GPIO_W];

   // ****************************************************************
   // Wake source decode
   // ****************************************************************

   // Only the selected pin carries the wake function, others stay interrupts
   assign wake_mask = pin_mask(wake_pin_sel_i) & {GPIO_W{wake_pin_en_i}};
   assign wake_lvl  = |(gpio_s & wake_mask);
   assign gpio_rise = gpio_s & ~gpio_prev_q;
   assign gpio_evt  = |(gpio_rise & gpio_irq_en_i & ~wake_mask);
   assign rtc_evt   = tick_q & rtc_alarm_en_i & (rtc_cnt_q == rtc_alarm_i);

   // Hardware sources only; no software request appears here
   assign src.wake_pin = wake_lvl;
   assign src.gpio     = gpio_evt;
   assign src.radio    = radio_activity_i;
   assign src.rtc      = rtc_evt;
   assign any_wake     = |src;

   // Handler pending after a GPIO wake; a new event beats the done strobe
   assign busy_d  = gpio_evt | (busy_q & ~irq_done_i);

   // Deep sleep only with nothing holding the module awake
   assign deep_ok = sleep_en_i & ~wake_lvl & ~busy_q & ~any_wake;

   // ****************************************************************
   // RTC time base and watchdog
   // ****************************************************************

   // Watchdog counts only while the core clock domain is alive
   assign wdog_run    = (state_q == ST_ACTIVE) || (state_q == ST_LIGHT);
   assign wdog_expire = wdog_run & tick_q & (wdog_cnt_q == WDOG_TICKS - 1'b1);

   // RTC divider and counter, cleared only by power-up reset
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         div_cnt_q <= '0;
         tick_q    <= 1'b0;
         rtc_cnt_q <= RTC_CNT_RST;
      end else begin
         tick_q    <= (div_cnt_q == RTC_DIV_CYC - 1'b1);
         div_cnt_q <= (div_cnt_q == RTC_DIV_CYC - 1'b1) ? '0 : div_cnt_q + 1'b1;
         if (tick_q) begin
            rtc_cnt_q <= rtc_cnt_q + 1'b1;
         end
      end
   end

   // Watchdog counter
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || rst_any || wdog_kick_i) begin
         wdog_cnt_q <= '0;
      end else if (wdog_run && tick_q) begin
         wdog_cnt_q <= wdog_cnt_q + 1'b1;
      end
   end

   // ****************************************************************
   // Reset sources
   // ****************************************************************

   // Internal resets start a pull-down pulse on the reset pin
   assign rst_cnt_d = wdog_expire       ? RST_PULSE_CYC :
                      (rst_cnt_q != '0) ? rst_cnt_q - 1'b1 : rst_cnt_q;
   assign rst_any   = (rst_cnt_q != '0) | ~pin_s;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         rst_cnt_q <= RST_PULSE_CYC;
         pin_oe_q  <= 1'b1;
         pin_val_q <= 1'b0;
         sys_rst_q <= 1'b1;
      end else begin
         rst_cnt_q <= rst_cnt_d;
         pin_oe_q  <= (rst_cnt_d != '0);
         pin_val_q <= 1'b0;                                   // Pull-up gives the high
         sys_rst_q <= rst_any | wdog_expire;
      end
   end

   // ****************************************************************
   // Power state machine
   // ****************************************************************

   // Next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RESET: begin
            if (!rst_any) begin
               state_d = ST_WAKING;
            end
         end
         ST_WAKING: begin
            if (wake_cnt_q == '0) begin
               state_d = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (core_idle_i) begin
               state_d = deep_ok ? ST_DEEP : ST_LIGHT;
            end
         end
         ST_LIGHT: begin
            if (src.gpio || src.radio || src.rtc || !core_idle_i) begin
               state_d = ST_ACTIVE;
            end else if (deep_ok) begin
               state_d = ST_DEEP;
            end
         end
         ST_DEEP: begin
            if (any_wake) begin
               state_d = ST_WAKING;
            end
         end
         default: begin
            state_d = ST_RESET;
         end
      endcase
      if (rst_any || wdog_expire) begin
         state_d = ST_RESET;
      end
   end

   assign enter_wake = (state_d == ST_WAKING) && (state_q != ST_WAKING);

   // State, wake delay and wake cause
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_q     <= ST_RESET;
         wake_cnt_q  <= WAKE_DELAY_CYC;
         busy_q      <= 1'b0;
         gpio_prev_q <= '0;
         cause_q     <= WAKE_NONE;
      end else begin
         state_q     <= state_d;
         busy_q      <= busy_d;
         gpio_prev_q <= gpio_s;
         if (enter_wake) begin
            wake_cnt_q <= WAKE_DELAY_CYC;
         end else if (state_q == ST_WAKING && wake_cnt_q != '0) begin
            wake_cnt_q <= wake_cnt_q - 1'b1;
         end
         if (any_wake && (state_q == ST_DEEP || state_q == ST_LIGHT)) begin
            cause_q <= src;
         end
      end
   end

   // ****************************************************************
   // Registered outputs
   // ****************************************************************

   // Controls follow the next state so they change with the state flop
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         pwr_q  <= PWR_RESET;
         flow_q <= 1'b0;
      end else begin
         pwr_q  <= ctrl_for(state_d);
         flow_q <= (state_d == ST_ACTIVE) || (state_d == ST_LIGHT);
      end
   end

   assign pwr_ctrl_o        = pwr_q;
   assign pwr_state_o       = state_q;
   assign wake_cause_o      = cause_q;
   assign sys_reset_o       = sys_rst_q;
   assign uart_flow_ready_o = flow_q;
   assign gpio_busy_o       = busy_q;
   assign rtc_count_o       = rtc_cnt_q;
   assign reset_pin_o       = pin_val_q;
   assign reset_pin_oe_o    = pin_oe_q;

endmodule

/* File: tb/host_model.sv */
`timescale 1ns/10ps
// ****************************************************************
// Host processor beyond the wake pin, flow control and reset pad
// ****************************************************************
module host_model (
   input  wire logic       sys_clk_i,
   input  wire logic       send_i,
   input  wire logic [7:0] len_i,
   input  wire logic       pull_rst_i,
   input  wire logic       dev_oe_i,
   input  wire logic       flow_i,
   output logic            wake_o,
   output logic            pad_o,
   output logic            lost_o
);
   logic [7:0] left_q;

   // Idle host at power-up
   initial begin
      wake_o = 1'b0;
      lost_o = 1'b0;
      left_q = 8'h00;
   end

   // Open-drain pad: either side only pulls low, the pull-up releases it
   assign pad_o = !(pull_rst_i || dev_oe_i);

   // One byte a cycle, wake pin held around the whole transfer
   always @(posedge sys_clk_i) begin
      if (send_i) begin
         wake_o <= 1'b1;
         left_q <= len_i;
      end else if (wake_o && left_q == 8'h00) begin
         wake_o <= 1'b0;
      end else if (wake_o && flow_i) begin
         left_q <= left_q - 8'h01;
      end else if (wake_o && left_q != len_i) begin
         lost_o <= 1'b1; // Flow dropped mid-transfer
      end
   end
endmodule

/* File: tb/power_state_ctrl_assertions.sv */
`timescale 1ns/10ps
// ****************************************************************
// Port checker for the sleep, wake and reset sequencer
// ****************************************************************
module power_state_ctrl_assertions #(
   parameter logic [power_pkg::WDOG_W-1:0] WDOG_TICKS = power_pkg::WDOG_TICKS_DEF
) (
   input logic                          sys_clk_i,
   input logic                          reset_i,
   input logic                          reset_pin_i,
   input logic                          reset_pin_o,
   input logic                          reset_pin_oe_o,
   input logic [power_pkg::GPIO_W-1:0]  gpio_i,
   input logic                          wake_pin_en_i,
   input logic [power_pkg::SEL_W-1:0]   wake_pin_sel_i,
   input power_pkg::pwr_ctrl_s          pwr_ctrl_o,
   input power_pkg::pwr_state_e         pwr_state_o,
   input power_pkg::wake_src_s          wake_cause_o,
   input logic                          sys_reset_o,
   input logic                          uart_flow_ready_o,
   input logic                          gpio_busy_o
);
   import power_pkg::*;

   logic       wake_lvl;
   logic [9:0] wake_cnt_q;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   // Level of the selected wake pin
   assign wake_lvl = wake_pin_en_i && (wake_pin_sel_i < 4'hA) && gpio_i[wake_pin_sel_i];

   // Cycles spent in the waking state
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || pwr_state_o != ST_WAKING) begin
         wake_cnt_q <= 10'h000;
      end else begin
         wake_cnt_q <= wake_cnt_q + 10'h001;
      end
   end

   property p_light;
      pwr_state_o == ST_LIGHT |-> !pwr_ctrl_o.core_run && pwr_ctrl_o.sys_clk_on
         && pwr_ctrl_o.periph_on && pwr_ctrl_o.uart_on;
   endproperty
   a_light: assert property (p_light) else $error("light sleep controls wrong");
   property p_deep;
      pwr_state_o == ST_DEEP |-> !pwr_ctrl_o.sys_clk_on && !pwr_ctrl_o.uart_on
         && !pwr_ctrl_o.core_run && !uart_flow_ready_o;
   endproperty
   a_deep: assert property (p_deep) else $error("deep sleep not gated");
   property p_pin_holds;
      wake_lvl [*4] |=> pwr_state_o != ST_DEEP;
   endproperty
   a_pin_holds: assert property (p_pin_holds) else $error("deep sleep with pin high");
   property p_deep_exit;
      $past(pwr_state_o) == ST_DEEP |-> (pwr_state_o inside {ST_DEEP, ST_RESET})
         || (pwr_state_o == ST_WAKING && wake_cause_o != WAKE_NONE);
   endproperty
   a_deep_exit: assert property (p_deep_exit) else $error("deep left without cause");
   property p_busy_awake;
      gpio_busy_o && pwr_state_o != ST_DEEP |=> pwr_state_o != ST_DEEP;
   endproperty
   a_busy_awake: assert property (p_busy_awake) else $error("slept with handler busy");
   property p_flow_delay;
      $rose(uart_flow_ready_o) && $past(pwr_state_o) == ST_WAKING
         |-> wake_cnt_q >= 10'(WAKE_DELAY_CYC);
   endproperty
   a_flow_delay: assert property (p_flow_delay) else $error("flow ready too early");
   property p_retain;
      pwr_ctrl_o.ram_retain && pwr_ctrl_o.rtc_run;
   endproperty
   a_retain: assert property (p_retain) else $error("retention or rtc off");
   property p_pad_low;
      !reset_pin_i [*4] |=> sys_reset_o;
   endproperty
   a_pad_low: assert property (p_pad_low) else $error("pad low without reset");
   property p_pin_drive;
      reset_pin_oe_o |-> !reset_pin_o;
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("pad driven high");

   c_deep: cover property (pwr_state_o == ST_DEEP);
   c_gpio: cover property (wake_cause_o.gpio && gpio_busy_o);
   c_pulse: cover property ($rose(reset_pin_oe_o));
endmodule

bind power_state_ctrl power_state_ctrl_assertions #(.WDOG_TICKS(WDOG_TICKS)) u_chk (
   .sys_clk_i, .reset_i, .reset_pin_i, .reset_pin_o, .reset_pin_oe_o, .gpio_i,
   .wake_pin_en_i, .wake_pin_sel_i, .pwr_ctrl_o, .pwr_state_o, .wake_cause_o,
   .sys_reset_o, .uart_flow_ready_o, .gpio_busy_o
);

/* File: tb/power_state_ctrl_test.sv */
`timescale 1ns/10ps
// ****************************************************************
// Bench for the sleep, wake and reset sequencer
// ****************************************************************
module power_state_ctrl_test;
   import power_pkg::*;

   logic              clk;
   logic              rst;
   logic [GPIO_W-1:0] gpio_drv;
   logic [GPIO_W-1:0] gpio;
   logic              idle;
   logic              sleep_en;
   logic              irq_done;
   logic              radio;
   logic              alarm_en;
   logic [RTC_W-1:0]  alarm;
   logic [SEL_W-1:0]  wake_sel;
   logic              kick;
   logic              send;
   logic              pull_rst;
   logic              wake;
   logic              pad;
   logic              lost;
   logic              pin_oe;
   logic              sys_rst;
   logic              flow;
   logic              busy;
   logic [RTC_W-1:0]  rtc;
   pwr_ctrl_s         ctrl;
   pwr_state_e        st;
   wake_src_s         cause;
   int                err_count;
   int                num_checks;

   // Wake pin sits on GPIO 3
   assign gpio = gpio_drv | {6'h00, wake, 3'h0};

   power_state_ctrl #(.WDOG_TICKS(16'h0004)) u_dut (
      .sys_clk_i         (clk),
      .reset_i           (rst),
      .reset_pin_i       (pad),
      .reset_pin_o       (),
      .reset_pin_oe_o    (pin_oe),
      .gpio_i            (gpio),
      .gpio_irq_en_i     (10'h028),
      .wake_pin_en_i     (1'b1),
      .wake_pin_sel_i    (wake_sel),
      .sleep_en_i        (sleep_en),
      .core_idle_i       (idle),
      .irq_done_i        (irq_done),
      .radio_activity_i  (radio),
      .rtc_alarm_en_i    (alarm_en),
      .rtc_alarm_i       (alarm),
      .wdog_kick_i       (kick),
      .pwr_ctrl_o        (ctrl),
      .pwr_state_o       (st),
      .wake_cause_o      (cause),
      .sys_reset_o       (sys_rst),
      .uart_flow_ready_o (flow),
      .gpio_busy_o       (busy),
      .rtc_count_o       (rtc)
   );

   host_model u_host (
      .sys_clk_i  (clk),
      .send_i     (send),
      .len_i      (8'h40),
      .pull_rst_i (pull_rst),
      .dev_oe_i   (pin_oe),
      .flow_i     (flow),
      .wake_o     (wake),
      .pad_o      (pad),
      .lost_o     (lost)
   );

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic complete_run;
      if (err_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic wait_st(input pwr_state_e s, input int lim);
      for (int n = 0; n < lim && st !== s; n++) begin
         @(negedge clk);
      end
      chk("state", 16'(s), 16'(st));
      if (st !== s) begin
         complete_run();
      end
   endtask

   task automatic t_reset;
      rst = 1'b1;
      repeat (20) @(negedge clk);
      chk("ctrl", 16'(PWR_RESET), 16'(ctrl));
      chk("rtc", RTC_CNT_RST, rtc);
      rst = 1'b0;
      repeat (150) @(negedge clk);
      chk("pin_oe", 16'h0001, 16'(pin_oe));
      chk("sys_reset", 16'h0001, 16'(sys_rst));
      wait_st(ST_ACTIVE, 1000);
      chk("pin_oe", 16'h0000, 16'(pin_oe));
      chk("flow", 16'h0001, 16'(flow));
   endtask

   task automatic t_light;
      idle = 1'b1;
      wait_st(ST_LIGHT, 20);
      chk("flow", 16'h0001, 16'(flow));
      idle = 1'b0;
      wait_st(ST_ACTIVE, 20);
   endtask

   task automatic t_deep;
      logic [RTC_W-1:0] c;
      sleep_en = 1'b1;
      idle = 1'b1;
      wait_st(ST_DEEP, 20);
      chk("uart_on", 16'h0000, 16'(ctrl.uart_on));
      c = rtc;
      irq_done = 1'b1;
      repeat (305) @(negedge clk);
      irq_done = 1'b0;
      chk("rtc", c + 16'h0001, rtc);
      chk("state", 16'(ST_DEEP), 16'(st));
   endtask

   task automatic t_pin_wake;
      send = 1'b1;
      @(negedge clk);
      send = 1'b0;
      wait_st(ST_WAKING, 10);
      chk("cause", 16'h0008, 16'(cause));
      repeat (400) @(negedge clk);
      chk("flow", 16'h0000, 16'(flow));
      wait_st(ST_LIGHT, 200);
      chk("busy", 16'h0000, 16'(busy));
      wait_st(ST_DEEP, 200);
      chk("lost", 16'h0000, 16'(lost));
   endtask

   task automatic t_sources;
      gpio_drv[6] = 1'b1;
      repeat (10) @(negedge clk);
      chk("state", 16'(ST_DEEP), 16'(st));
      // Moving the wake function onto the high pin wakes and names the pin
      wake_sel = 4'h6;
      wait_st(ST_WAKING, 10);
      chk("cause", 16'h0008, 16'(cause));
      gpio_drv[6] = 1'b0;
      wake_sel = 4'h3;
      wait_st(ST_DEEP, 700);
      for (int k = 0; k < 3; k++) begin
         gpio_drv = {4'h0, k == 0, 5'h00};
         radio = (k == 1);
         alarm = rtc + 16'h0002;
         alarm_en = (k == 2);
         wait_st(ST_WAKING, 1000);
         chk("cause", 16'(4'h4 >> k), 16'(cause));
         {gpio_drv, radio, alarm_en} = '0;
         if (k == 0) begin
            wait_st(ST_LIGHT, 600);
            chk("busy", 16'h0001, 16'(busy));
            irq_done = 1'b1;
            @(negedge clk);
            irq_done = 1'b0;
         end
         wait_st(ST_DEEP, 600);
      end
   endtask

   task automatic t_ext_reset;
      idle = 1'b0;
      pull_rst = 1'b1;
      repeat (10) @(negedge clk);
      chk("sys_reset", 16'h0001, 16'(sys_rst));
      pull_rst = 1'b0;
      wait_st(ST_ACTIVE, 1000);
   endtask

   task automatic t_wdog;
      kick = 1'b0;
      for (int n = 0; n < 1400 && sys_rst !== 1'b1; n++) begin
         @(negedge clk);
      end
      chk("sys_reset", 16'h0001, 16'(sys_rst));
      chk("pin_oe", 16'h0001, 16'(pin_oe));
      kick = 1'b1;
      wait_st(ST_ACTIVE, 1000);
   endtask

   // Main sequence
   initial begin
      err_count = 0;
      num_checks = 0;
      {gpio_drv, idle, sleep_en, irq_done, radio, alarm_en, alarm, send, pull_rst} = '0;
      kick = 1'b1;
      wake_sel = 4'h3;
      t_reset();
      t_light();
      t_deep();
      t_pin_wake();
      t_sources();
      t_ext_reset();
      t_wdog();
      t_reset();
      complete_run();
   end
endmodule
